//--- include/srb_pkg.sv
package srb_pkg;
  // reading and trip level width
  localparam int LEVEL_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LEVEL1 = 8'h04;
  localparam logic [7:0] OFS_LEVEL4 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MENU   = 8'h18;
  // control register fields
  localparam int CTRL_TRI_BIT    = 0;
  localparam int CTRL_BAND_BIT   = 1;
  localparam int CTRL_BRIGHT_LSB = 8;
  localparam int BRIGHT_W        = 8;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_ff01;
  localparam logic [15:0] LEVEL_RESET = 16'h0000;
  // status register fields
  localparam int STAT_RELAY_LSB = 0;
  localparam int STAT_HUE_LSB   = 4;
  localparam int STAT_MENU_LSB  = 8;
  localparam int STAT_LOCK_BIT  = 12;
  localparam int STAT_DIM_BIT   = 13;
  // menu register fields
  localparam int MENU_DIR_LSB = 0;
  localparam int MENU_HUE_LSB = 4;
  // trip direction codes, reset values of the menu settings
  localparam logic       DIR_BELOW = 1'b0;
  localparam logic       DIR_ABOVE = 1'b1;
  localparam logic [3:0] DIR_RESET = 4'hf;
  localparam logic [9:0] HUE_RESET = 10'h2a4;
  // last digit and last colour step of the menu
  localparam logic [2:0] DIR_LAST = 3'h3;
  localparam logic [2:0] HUE_LAST = 3'h4;
  // blink timing of flashing digits and prompts
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYCLES  = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // bar colour codes
  typedef enum logic [1:0]
  {
    HUE_GREEN  = 2'h0,
    HUE_ORANGE = 2'h1,
    HUE_RED    = 2'h2
  } srb_hue_t;
  // menu states, one-hot
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_DIR  = 3'b010,
    ST_HUE  = 3'b100
  } srb_menu_t;
  // front keys, one-cycle pulses
  typedef struct packed
  {
    logic up;
    logic down;
    logic advance;
    logic commit;
  } srb_keys_t;
  // tricolour bar drive
  typedef struct packed
  {
    logic green;
    logic orange;
    logic red;
  } srb_bar_t;
endpackage

//--- core/srb_eval.sv
// comparisons of one reading against the four trip levels
module srb_eval #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]      reading,
  input  wire logic [3:0][W-1:0] levels,
  input  wire logic [3:0]        dirs,
  input  wire logic [4:0][1:0]   hues,
  input  wire logic              band_on,
  input  wire logic              relay1_q,
  output logic [3:0]             next_relay,
  output logic [1:0]             next_hue
);
  logic [3:0]          above;    // reading exceeds level
  logic [3:0]          below;    // reading under level
  logic                found;    // some level exceeded
  logic signed [W-1:0] best;     // highest exceeded level
  logic [2:0]          pick;     // colour slot chosen

  // relay terms and colour zone search
  always_comb
  begin
    found = 1'b0;
    best  = '0;
    pick  = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      above[i] = $signed(reading) > $signed(levels[i]);
      below[i] = $signed(reading) < $signed(levels[i]);
      // above or below trip per direction
      next_relay[i] = (dirs[i] == srb_pkg::DIR_ABOVE) ? above[i]
                                                     : below[i]; // [RULE1] [RULE2]
      // equal levels: later index wins through >=
      if (above[i] && (!found || $signed(levels[i]) >= best)) // [RULE10] [RULE11]
      begin
        found = 1'b1;
        best  = $signed(levels[i]);
        pick  = 3'(i + 1);
      end
    end
    // band latch on first relay when second level is higher
    if (band_on && $signed(levels[1]) > $signed(levels[0])) // [RULE17]
    begin
      if (dirs[0] == srb_pkg::DIR_BELOW)
        next_relay[0] = below[0] | (relay1_q & below[1]);
      else
        next_relay[0] = above[1] | (relay1_q & above[0]);
    end
    // below every level: separate colour slot 0
    next_hue = hues[pick]; // [RULE9]
  end
endmodule

//--- core/srb_top.sv
// Function
// [RULE1] above direction: relay on while reading exceeds
// [RULE2] below direction: relay on while reading below
// [RULE3] four direction digits, left is first
// [RULE4] up/down toggle digit; advance flashes next
// [RULE5] mono display: commit fourth digit, exit
// [RULE6] tricolour: commit fourth digit, enter colours
// [RULE7] bar lit in exactly one colour
// [RULE8] whole bar takes new zone colour
// [RULE9] below all levels uses below colour
// [RULE10] above a level uses its colour
// [RULE11] equal levels: highest numbered colour wins
// [RULE12] up/down cycle green, orange, red
// [RULE13] colour menu steps below, then first-fourth
// [RULE14] fourth colour accepted ends programming
// [RULE15] dim input halves programmed brightness
// [RULE16] lockout allows viewing, refuses changes
// [RULE17] band option latches first relay between levels
// [RULE18] relays and colour update per new reading
// [RULE19] menu settings take effect at final step
//
// The placing of the registers and the APB slave port are this design's own decisions.
module srb_top #(
  parameter int LEVEL_W      = srb_pkg::LEVEL_W,
  parameter int BLINK_CYCLES = srb_pkg::BLINK_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // converted reading
  input  wire logic [LEVEL_W-1:0]    reading,
  input  wire logic                  reading_valid,
  // front keys and menu entry
  input  wire srb_pkg::srb_keys_t    keys,
  input  wire logic                  menu_start,
  // rear contacts, low when tied to common
  input  wire logic                  dim_n,
  input  wire logic                  lock_n,
  // relays, annunciators, bar
  output logic [3:0]                 relay,
  output logic [3:0]                 lamp,
  output srb_pkg::srb_bar_t          bar,
  output logic [srb_pkg::BRIGHT_W-1:0] bright_level,
  // menu display
  output logic                       menu_active,
  output logic [3:0]                 dir_digits,
  output logic [3:0]                 digit_dp,
  output logic [3:0]                 digit_blank,
  output logic                       hue_prompt,
  output logic [2:0]                 hue_index,
  output logic [1:0]                 hue_value
);
  // elaboration checks
  if (LEVEL_W < 2 || LEVEL_W > 32)
    $error("LEVEL_W must lie in 2..32");
  if (BLINK_CYCLES < 2)
    $error("BLINK_CYCLES must be at least 2");

  localparam int CW = $clog2(BLINK_CYCLES);

  // next colour code, wrapping green-orange-red
  function automatic logic [1:0] hue_step(input logic [1:0] h,
                                          input logic       up);
    if (up)
      hue_step = (h == srb_pkg::HUE_RED) ? srb_pkg::HUE_GREEN
                                         : 2'(h + 2'h1);
    else
      hue_step = (h == srb_pkg::HUE_GREEN) ? srb_pkg::HUE_RED
                                           : 2'(h - 2'h1);
  endfunction

  logic [31:0]              ctrl;        // control register
  logic [3:0][LEVEL_W-1:0]  levels;      // trip levels
  logic [3:0]               dirs;        // active directions
  logic [4:0][1:0]          hues;        // active colours
  logic [3:0]               edit_dirs;   // directions in edit
  logic [4:0][1:0]          edit_hues;   // colours in edit
  srb_pkg::srb_menu_t       state;       // menu state
  logic [2:0]               idx;         // digit or colour step
  logic [CW-1:0]            blink_cnt;   // blink divider
  logic                     blink_phase; // on/off half of blink
  logic [1:0]               cur_hue;     // colour shown by bar

  // combinational menu results
  srb_pkg::srb_menu_t       next_state;
  logic [2:0]               next_idx;
  logic [3:0]               next_edit_dirs;
  logic [4:0][1:0]          next_edit_hues;
  logic                     apply;       // final step accepted

  // evaluation results
  logic [3:0]               next_relay;
  logic [1:0]               next_hue;

  // decode of rear contacts and control fields
  wire locked  = ~lock_n;
  wire dimmed  = ~dim_n;
  wire tri_on  = ctrl[srb_pkg::CTRL_TRI_BIT];
  wire band_on = ctrl[srb_pkg::CTRL_BAND_BIT];
  wire [srb_pkg::BRIGHT_W-1:0] bright =
    ctrl[srb_pkg::CTRL_BRIGHT_LSB +: srb_pkg::BRIGHT_W];
  wire can_edit = ~locked; // [RULE16]

  // apb address decode
  wire       aligned  = (paddr[1:0] == 2'h0);
  wire       hit_ctrl = aligned && (paddr == srb_pkg::OFS_CTRL);
  wire       hit_stat = aligned && (paddr == srb_pkg::OFS_STATUS);
  wire       hit_menu = aligned && (paddr == srb_pkg::OFS_MENU);
  wire       hit_lvl  = aligned && (paddr >= srb_pkg::OFS_LEVEL1) &&
                        (paddr <= srb_pkg::OFS_LEVEL4);
  wire [1:0] lvl_idx  = 2'((paddr - srb_pkg::OFS_LEVEL1) >> 2);
  wire       hit_any  = hit_ctrl | hit_stat | hit_menu | hit_lvl;
  wire       rd_only  = hit_stat | hit_menu;
  // writes refused when unmapped, read-only or locked
  wire       bad      = ~hit_any | (pwrite & (rd_only | locked)); // [RULE16]
  wire       setup    = psel & ~penable;
  wire       wr_ok    = psel & penable & pready & pwrite & ~pslverr;
  wire       wr_ctrl  = wr_ok & hit_ctrl;
  wire       wr_lvl   = wr_ok & hit_lvl;

  // status and menu words
  wire [31:0] stat_word =
    (32'(relay) << srb_pkg::STAT_RELAY_LSB) |
    (32'(cur_hue) << srb_pkg::STAT_HUE_LSB) |
    (32'(state) << srb_pkg::STAT_MENU_LSB) |
    (32'(locked) << srb_pkg::STAT_LOCK_BIT) |
    (32'(dimmed) << srb_pkg::STAT_DIM_BIT);
  wire [31:0] menu_word =
    (32'(dirs) << srb_pkg::MENU_DIR_LSB) |
    (32'(hues) << srb_pkg::MENU_HUE_LSB);

  // read data select, zero for unmapped
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl :
    hit_lvl  ? 32'($unsigned(levels[lvl_idx])) :
    hit_stat ? stat_word :
    hit_menu ? menu_word : 32'h0000_0000;

  // apb answer: no wait state, data captured in setup
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= bad;
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // control register write
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ctrl <= srb_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= pwdata;
  end

  // trip level write
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      levels <= {4{LEVEL_W'(srb_pkg::LEVEL_RESET)}};
    else if (wr_lvl)
      levels[lvl_idx] <= pwdata[LEVEL_W-1:0];
  end

  // blink divider, one-cycle wrap toggles phase
  wire blink_tick = (blink_cnt == CW'(BLINK_CYCLES - 1));
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end
    else if (blink_tick)
    begin
      blink_cnt   <= '0;
      blink_phase <= ~blink_phase;
    end
    else
      blink_cnt <= CW'(blink_cnt + 1'b1);
  end

  // menu sequencing, one key taken per cycle
  always_comb
  begin
    next_state     = state;
    next_idx       = idx;
    next_edit_dirs = edit_dirs;
    next_edit_hues = edit_hues;
    apply          = 1'b0;
    unique case (state)
      srb_pkg::ST_IDLE:
        // edit copies start from the active settings
        if (menu_start)
        begin
          next_state     = srb_pkg::ST_DIR;
          next_idx       = 3'h0;
          next_edit_dirs = dirs;
          next_edit_hues = hues;
        end
      srb_pkg::ST_DIR:
        if (keys.commit && idx == srb_pkg::DIR_LAST)
        begin
          if (tri_on)
          begin
            // colour menu from the below-all slot
            next_state = srb_pkg::ST_HUE; // [RULE6]
            next_idx   = 3'h0;
          end
          else
          begin
            // mono display leaves programming
            next_state = srb_pkg::ST_IDLE; // [RULE5]
            apply      = 1'b1;
          end
        end
        else if (keys.advance && idx != srb_pkg::DIR_LAST)
          next_idx = 3'(idx + 3'h1); // [RULE4]
        else if (can_edit && (keys.up || keys.down))
          next_edit_dirs[idx[1:0]] = ~edit_dirs[idx[1:0]]; // [RULE4]
      srb_pkg::ST_HUE:
        if (keys.advance || keys.commit)
        begin
          if (idx == srb_pkg::HUE_LAST)
          begin
            // fourth colour accepted
            next_state = srb_pkg::ST_IDLE; // [RULE14]
            apply      = 1'b1;
          end
          else
            next_idx = 3'(idx + 3'h1); // [RULE13]
        end
        else if (can_edit && (keys.up || keys.down))
          next_edit_hues[idx] = hue_step(edit_hues[idx], keys.up); // [RULE12]
    endcase
  end

  // menu registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= srb_pkg::ST_IDLE;
      idx       <= 3'h0;
      edit_dirs <= srb_pkg::DIR_RESET;
      edit_hues <= srb_pkg::HUE_RESET;
    end
    else
    begin
      state     <= next_state;
      idx       <= next_idx;
      edit_dirs <= next_edit_dirs;
      edit_hues <= next_edit_hues;
    end
  end

  // active settings change only at the final step
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      dirs <= srb_pkg::DIR_RESET;
      hues <= srb_pkg::HUE_RESET;
    end
    else if (apply && can_edit) // [RULE19] [RULE16]
    begin
      dirs <= edit_dirs;
      hues <= edit_hues;
    end
  end

  // comparisons against the active settings
  srb_eval #(
    .W (LEVEL_W)
  ) u_eval (
    .reading    (reading),
    .levels     (levels),
    .dirs       (dirs),
    .hues       (hues),
    .band_on    (band_on),
    .relay1_q   (relay[0]),
    .next_relay (next_relay),
    .next_hue   (next_hue)
  );

  // relays, lamps and colour updated together per reading
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      relay   <= 4'h0;
      lamp    <= 4'h0;
      cur_hue <= srb_pkg::HUE_GREEN;
      bar     <= '{green: 1'b1, orange: 1'b0, red: 1'b0};
    end
    else if (reading_valid) // [RULE18]
    begin
      relay   <= next_relay;
      lamp    <= next_relay;
      cur_hue <= next_hue;
      // one colour only, whole bar switches at once
      bar.green  <= (next_hue == srb_pkg::HUE_GREEN); // [RULE7] [RULE8]
      bar.orange <= (next_hue == srb_pkg::HUE_ORANGE); // [RULE7]
      bar.red    <= (next_hue == srb_pkg::HUE_RED); // [RULE7]
    end
  end

  // editing digit as one-hot
  wire [3:0] dir_sel = (state == srb_pkg::ST_DIR) ? 4'(4'h1 << idx[1:0])
                                                   : 4'h0;

  // display drive, registered
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      bright_level <= '0;
      menu_active  <= 1'b0;
      dir_digits   <= 4'h0;
      digit_dp     <= 4'h0;
      digit_blank  <= 4'h0;
      hue_prompt   <= 1'b0;
      hue_index    <= 3'h0;
      hue_value    <= 2'h0;
    end
    else
    begin
      // half brightness while dim contact is closed
      bright_level <= dimmed ? (bright >> 1) : bright; // [RULE15]
      menu_active  <= (state != srb_pkg::ST_IDLE);
      // digit order left to right, first to fourth
      dir_digits   <= (state == srb_pkg::ST_DIR) ? edit_dirs : dirs; // [RULE3]
      // edited digit flashes with its point lit
      digit_dp     <= dir_sel; // [RULE4]
      digit_blank  <= dir_sel & {4{blink_phase}}; // [RULE4]
      // prompt alternates with the prior value
      hue_prompt   <= (state == srb_pkg::ST_HUE) & blink_phase; // [RULE13]
      hue_index    <= idx;
      hue_value    <= edit_hues[idx];
    end
  end
endmodule

//--- testbench/srb_checker.sv
// port-level watch of relays, bar, menu and lockout
module srb_checker (
  input wire logic                         clock,
  input wire logic                         resetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic                         pslverr,
  input wire logic                         reading_valid,
  input wire logic                         menu_start,
  input wire logic                         dim_n,
  input wire logic                         lock_n,
  input wire logic [3:0]                   relay,
  input wire logic [3:0]                   lamp,
  input wire srb_pkg::srb_bar_t            bar,
  input wire logic [srb_pkg::BRIGHT_W-1:0] bright_level,
  input wire logic                         menu_active,
  input wire logic [3:0]                   digit_dp,
  input wire logic [3:0]                   digit_blank,
  input wire logic                         hue_prompt,
  input wire logic [2:0]                   hue_index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // exactly one colour lit
  property p_one_hue;
    $onehot(bar);
  endproperty
  a_one_hue: assert property (p_one_hue)
    else $error("bar not one colour");
  // relays move only on a new reading
  property p_relay_hold;
    !reading_valid |=> $stable(relay);
  endproperty
  a_relay_hold: assert property (p_relay_hold)
    else $error("relay moved without reading");
  // bar moves only on a new reading, all segments at once
  property p_bar_hold;
    !reading_valid |=> $stable(bar);
  endproperty
  a_bar_hold: assert property (p_bar_hold)
    else $error("bar moved without reading");
  // annunciator mirrors its relay
  property p_lamp;
    lamp == relay;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp differs from relay");
  // dim contact held: at most half brightness
  property p_dim;
    !dim_n [*2] |-> bright_level[7] == 1'b0;
  endproperty
  a_dim: assert property (p_dim)
    else $error("dim not halving");
  // writes refused while locked
  property p_lock;
    psel && !penable && pwrite && !lock_n |=> pslverr;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write accepted");
  // menu opens on the first digit
  property p_first_digit;
    $rose(menu_active) |-> digit_dp == 4'b0001;
  endproperty
  a_first_digit: assert property (p_first_digit)
    else $error("menu not on first digit");
  // entry shows two cycles after the start pulse
  property p_enter;
    menu_start && !menu_active |-> ##2 menu_active;
  endproperty
  a_enter: assert property (p_enter)
    else $error("menu not entered");
  // colour steps stay within five slots
  property p_step_range;
    menu_active |-> hue_index <= 3'h4;
  endproperty
  a_step_range: assert property (p_step_range)
    else $error("colour step out of range");
  // only the edited digit may flash
  property p_blank_in_dp;
    (digit_blank & ~digit_dp) == 4'h0;
  endproperty
  a_blank_in_dp: assert property (p_blank_in_dp)
    else $error("flash outside edited digit");
  // colour prompt only shown inside the menu
  property p_prompt_menu;
    hue_prompt |-> menu_active;
  endproperty
  a_prompt_menu: assert property (p_prompt_menu)
    else $error("prompt outside menu");
  // main scenarios reached
  c_relay: cover property (reading_valid ##1 relay != 4'h0);
  c_lock: cover property (!lock_n && pslverr);
  c_last_hue: cover property (menu_active && hue_index == 3'h4);
  c_blink: cover property (digit_blank != 4'h0);
endmodule

//--- testbench/srb_panel.sv
// front keys and rear contacts, as a user works them
module srb_panel (
  input  wire logic          clock,
  output srb_pkg::srb_keys_t keys,
  output logic               menu_start,
  output logic               dim_n,
  output logic               lock_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: no key, contacts open
  initial
  begin
    keys = '0;
    menu_start = 1'b0;
    dim_n = 1'b1;
    lock_n = 1'b1;
  end
  // one-cycle press, code is {start, up, down, advance, commit}
  task automatic press(input logic [4:0] k);
    @(posedge clock);
    {menu_start, keys} <= k;
    @(posedge clock);
    {menu_start, keys} <= 5'h00;
  endtask
  // close (1) or open (0) the rear contacts
  task automatic contacts(input logic dim, input logic lock);
    @(posedge clock);
    dim_n <= !dim;
    lock_n <= !lock;
  endtask
endmodule

//--- testbench/srb_top_bench.sv
// self-checking bench with a reference model of zones and menu
module srb_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, resetn, psel, penable, pwrite, reading_valid;
  logic [7:0]  paddr, bright_level;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, menu_start, dim_n, lock_n, menu_active;
  logic [15:0] reading;
  logic [3:0]  relay, lamp, dir_digits, digit_dp;
  logic [2:0]  hue_index;
  logic [1:0]  hue_value;
  srb_pkg::srb_keys_t keys;
  srb_pkg::srb_bar_t  bar;
  int          failures = 0, n_compared = 0, lv[4];
  int          lset[2][4] = '{'{-50, 0, 50, 100}, '{100, 20, 20, -30}};
  integer      seed = 32'ha7ad5e79;
  logic [3:0]  dirs = srb_pkg::DIR_RESET;       // model directions
  logic [1:0]  hs[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2}; // model colours
  bit          band = 1'b0;                // model band option
  logic [3:0]  mr = 4'h0;                  // model relays
  srb_panel i_panel (.clock, .keys, .menu_start, .dim_n, .lock_n);
  srb_top #(.BLINK_CYCLES(4)) i_dut (.clock, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reading,
    .reading_valid, .keys, .menu_start, .dim_n, .lock_n, .relay, .lamp,
    .bar, .bright_level, .menu_active, .dir_digits, .digit_dp,
    .digit_blank(), .hue_prompt(), .hue_index, .hue_value);
  // 125 MHz clock
  always #4 clock = ~clock;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1); // a hang is ended by the watchdog
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // write, checking the error flag
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("pslverr", {31'h0, x}, {31'h0, e});
  endtask
  // read, checking data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", d, q);
    chk("pslverr", {31'h0, x}, {31'h0, e});
  endtask
  // model view of the active settings register
  function automatic logic [31:0] menu_word();
    return {18'h0, hs[4], hs[3], hs[2], hs[1], hs[0], dirs};
  endfunction
  // key presses, then let the display catch up
  task automatic push(input logic [4:0] k, input int n);
    repeat (n) i_panel.press(k);
    @(posedge clock);
    @(negedge clock);
  endtask
  // one reading against the model's relays and zone colour
  task automatic feed(input int r);
    int         b;
    logic [1:0] h;
    logic [3:0] er;
    b = -1;
    for (int i = 0; i < 4; i++)
    begin
      er[i] = dirs[i] ? r > lv[i] : r < lv[i];
      if (r > lv[i] && (b < 0 || lv[i] >= lv[b]))
        b = i;
    end
    // band latch on the first relay, held between the two levels
    if (band && lv[1] > lv[0])
      er[0] = dirs[0] ? r > lv[1] || (mr[0] && r > lv[0])
                      : r < lv[0] || (mr[0] && r < lv[1]);
    mr = er;
    h = hs[b + 1];
    @(posedge clock);
    reading <= r[15:0];
    reading_valid <= 1'b1;
    @(posedge clock);
    reading_valid <= 1'b0;
    @(negedge clock);
    chk("relay", {28'h0, er}, {28'h0, relay});
    chk("bar", {29'h0, 3'b100 >> h}, {29'h0, bar});
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    conclude();
  end
  // main sequence
  initial
  begin
    clock = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, reading_valid} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reading = 16'h0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk("bar", 32'h4, {29'h0, bar});
    rd(srb_pkg::OFS_CTRL, srb_pkg::CTRL_RESET, 1'b0);
    rd(srb_pkg::OFS_MENU, menu_word(), 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    wr(srb_pkg::OFS_STATUS, 32'h1, 1'b1);
    // ordered levels with band latch, then unordered with a tie
    for (int s = 0; s < 2; s++)
    begin
      band = (s == 0);
      wr(srb_pkg::OFS_CTRL, {30'h0, band, 1'b0} | srb_pkg::CTRL_RESET, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
        lv[i] = lset[s][i];
        wr(srb_pkg::OFS_LEVEL1 + 8'(4 * i), {16'h0, 16'(lv[i])}, 1'b0);
        rd(srb_pkg::OFS_LEVEL1 + 8'(4 * i), {16'h0, 16'(lv[i])}, 1'b0);
      end
      for (int i = 0; i < 4; i++)
      begin
        feed(lv[i]);
        feed(lv[i] + 1);
        feed(lv[i] - 1);
      end
      repeat (20) feed($random(seed) % 150);
    end
    // single-colour display: menu ends after the fourth digit
    wr(srb_pkg::OFS_CTRL, 32'h0000_ff00, 1'b0);
    push(5'h10, 1);
    push(5'h08, 1);
    chk("dir_digits", 32'he, {28'h0, dir_digits});
    push(5'h02, 1);
    chk("digit_dp", 32'h2, {28'h0, digit_dp});
    push(5'h02, 2);
    push(5'h01, 1);
    chk("menu_active", 32'h0, {31'h0, menu_active});
    dirs = 4'he;
    rd(srb_pkg::OFS_MENU, menu_word(), 1'b0);
    // tricolour: direction menu leads into the colour menu
    wr(srb_pkg::OFS_CTRL, srb_pkg::CTRL_RESET, 1'b0);
    push(5'h10, 1);
    push(5'h02, 1);
    push(5'h08, 1);
    push(5'h02, 2);
    push(5'h01, 1);
    chk("hue_index", 32'h0, {29'h0, hue_index});
    chk("menu_active", 32'h1, {31'h0, menu_active});
    push(5'h08, 1);
    chk("hue_value", 32'h1, {30'h0, hue_value});
    push(5'h02, 1);
    push(5'h04, 1);
    push(5'h02, 3);
    chk("hue_index", 32'h4, {29'h0, hue_index});
    rd(srb_pkg::OFS_MENU, menu_word(), 1'b0);
    push(5'h01, 1);
    chk("menu_active", 32'h0, {31'h0, menu_active});
    dirs = 4'hc;
    hs[0] = 2'h1;
    hs[1] = 2'h0;
    rd(srb_pkg::OFS_MENU, menu_word(), 1'b0);
    repeat (20) feed($random(seed) % 150);
    // lockout: view only, menu edits and apply dropped
    i_panel.contacts(1'b0, 1'b1);
    wr(srb_pkg::OFS_LEVEL1, 32'h7, 1'b1);
    rd(srb_pkg::OFS_LEVEL1, {16'h0, 16'(lv[0])}, 1'b0);
    push(5'h10, 1);
    push(5'h08, 1);
    chk("dir_digits", 32'hc, {28'h0, dir_digits});
    push(5'h02, 3);
    push(5'h01, 6);
    chk("menu_active", 32'h0, {31'h0, menu_active});
    rd(srb_pkg::OFS_MENU, menu_word(), 1'b0);
    // dim contact halves brightness
    i_panel.contacts(1'b1, 1'b0);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("bright_level", 32'h7f, {24'h0, bright_level});
    i_panel.contacts(1'b0, 1'b0);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("bright_level", 32'hff, {24'h0, bright_level});
    conclude();
  end
endmodule
bind srb_top srb_checker i_chk (.clock, .resetn, .psel, .penable, .pwrite,
  .pslverr, .reading_valid, .menu_start, .dim_n, .lock_n, .relay, .lamp,
  .bar, .bright_level, .menu_active, .digit_dp, .digit_blank, .hue_prompt,
  .hue_index);
